/* pss_phase_gen.sv */
// four phase generator, one instruction cycle per rotation
`timescale 1ns/1ns
module pss_phase_gen
    import pss_pkg::*;
#(
    parameter int PHASE_COUNT = NUM_PHASES
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    output logic      [PHASE_COUNT-1:0] phase,
    output logic                        phase_first,
    output logic                        cycle_end
);

    logic [PHASE_COUNT-1:0] phase_ff;
    logic [PHASE_COUNT-1:0] nxt_phase;

    // rotating one-hot ring, never two phases at once
    always_comb begin
        nxt_phase = {phase_ff[PHASE_COUNT-2:0], phase_ff[PHASE_COUNT-1]};
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= PHASE_COUNT'(1);
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign phase       = phase_ff;
    assign phase_first = phase_ff[PH_T1];
    assign cycle_end   = phase_ff[PHASE_COUNT-1];

endmodule

/* pss_pkg.sv */
// shared constants and types for the program sequencer
package pss_pkg;

    // program counter layout
    localparam int PC_W    = 13;
    localparam int PC_LO_W = 8;
    localparam int PC_HI_W = PC_W - PC_LO_W;

    // instruction word fetched from program memory
    localparam int INSTR_W = 16;

    // instruction phases, one-hot, first phase in bit 0
    localparam int NUM_PHASES = 4;
    localparam int PH_T1      = 0;
    localparam int PH_T4      = NUM_PHASES - 1;

    // return address stack depth, must be a power of two
    localparam int STACK_DEPTH = 8;

    // reset values
    localparam logic [PC_W-1:0]    RESET_VECTOR = 13'h0000;
    localparam logic [INSTR_W-1:0] IDLE_WORD    = 16'h0000;

    typedef enum logic [1:0] {
        SEQ_RUN,
        SEQ_EXT,
        SEQ_DUMMY
    } pss_state_t;

    function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
        pc_inc = pc + PC_W'(1);
    endfunction

endpackage

/* pss_prog_mem.sv */
// behavioural program memory facing the sequencer fetch port
`timescale 1ns/1ns
module pss_prog_mem
    import pss_pkg::*;
(
    input  wire logic [PC_W-1:0]    prog_addr,
    input  wire logic               prog_rd_en,
    output logic      [INSTR_W-1:0] prog_data
);
    logic [INSTR_W-1:0] word;
    // each word carries its own address
    assign word = {3'h5, prog_addr};
    // not selected: drive the inverse so stale data never looks valid
    assign prog_data = prog_rd_en ? word : ~word;
endmodule

/* pss_ret_stack.sv */
// return address stack, circular storage with saturating level
`timescale 1ns/1ns
module pss_ret_stack
    import pss_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    output logic      [WIDTH-1:0] top_data,
    output logic                  full,
    output logic                  empty
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] nxt_wr_ptr;
    logic [PTR_W-1:0] top_idx;
    logic [CNT_W-1:0] level_ff;
    logic [CNT_W-1:0] nxt_level;

    always_comb begin
        top_idx    = wr_ptr_ff - PTR_W'(1);
        nxt_wr_ptr = wr_ptr_ff;
        nxt_level  = level_ff;
        if (push) begin
            // when full the write lands on the oldest entry
            nxt_wr_ptr = wr_ptr_ff + PTR_W'(1);
            if (!full) begin
                nxt_level = level_ff + CNT_W'(1);
            end
        end else if (pop && !empty) begin
            nxt_wr_ptr = top_idx;
            nxt_level  = level_ff - CNT_W'(1);
        end
        // empty pop leaves pointer alone and still shows the top slot
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            level_ff  <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            level_ff  <= nxt_level;
        end
    end

    // holds only pc values, no software path in or out
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= push_data;
        end
    end

    assign top_data = mem_ff[top_idx];
    assign full     = (level_ff == CNT_W'(DEPTH));
    assign empty    = (level_ff == '0);

endmodule

/* pss_sequencer.sv */
// program sequencer: phases, program counter, pipeline flush, return stack
`timescale 1ns/1ns
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int STACK_LEVELS = STACK_DEPTH
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    output logic      [NUM_PHASES-1:0] instruction_phases,
    output logic      [PC_W-1:0]       prog_addr,
    output logic                       prog_rd_en,
    input  wire logic [INSTR_W-1:0]    prog_data,
    output logic      [INSTR_W-1:0]    instr_word,
    output logic                       instr_valid,
    input  wire logic                  exec_ext,
    input  wire logic                  exec_jump,
    input  wire logic                  exec_call,
    input  wire logic                  exec_return,
    input  wire logic                  exec_int_return,
    input  wire logic                  exec_skip,
    input  wire logic [PC_W-1:0]       exec_target,
    input  wire logic                  pc_low_wr_en,
    input  wire logic [PC_LO_W-1:0]    pc_low_wr_data,
    output logic      [PC_LO_W-1:0]    program_counter_low,
    input  wire logic                  irq_req,
    input  wire logic [PC_W-1:0]       irq_vector,
    output logic                       irq_ack,
    output logic                       stack_full
);

    logic                  phase_first;
    logic                  cycle_end;

    pss_state_t            state_ff;
    pss_state_t            nxt_state;
    logic [PC_W-1:0]       pc_ff;
    logic [PC_W-1:0]       nxt_pc;
    logic [INSTR_W-1:0]    fetch_ff;
    logic [INSTR_W-1:0]    nxt_fetch;
    logic [INSTR_W-1:0]    exec_ir_ff;
    logic [INSTR_W-1:0]    nxt_exec_ir;

    logic                  active;
    logic                  take_ext;
    logic                  take_jump;
    logic                  take_ret;
    logic                  take_low;
    logic                  take_skip;
    logic                  take_irq;
    logic                  redirect;
    logic                  stk_push;
    logic                  stk_pop;
    logic [PC_W-1:0]       stk_top;
    logic                  stk_full;
    logic                  stk_empty;

    localparam int DUMMY_W = $clog2(NUM_PHASES + 1);
    logic [DUMMY_W-1:0]    dummy_len_ff;
    logic [DUMMY_W-1:0]    nxt_dummy_len;

    pss_phase_gen #(
        .PHASE_COUNT (NUM_PHASES)
    ) u_phase (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .phase       (instruction_phases),
        .phase_first (phase_first),
        .cycle_end   (cycle_end)
    );

    pss_ret_stack #(
        .DEPTH (STACK_LEVELS),
        .WIDTH (PC_W)
    ) u_stack (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .push      (stk_push),
        .pop       (stk_pop),
        .push_data (pc_ff),
        .top_data  (stk_top),
        .full      (stk_full),
        .empty     (stk_empty)
    );

    // decode of datapath requests, sampled only on the last phase
    always_comb begin
        active    = (state_ff != SEQ_DUMMY);
        take_ext  = active && (state_ff == SEQ_RUN) && exec_ext;
        take_jump = active && !take_ext && (exec_jump || exec_call);
        take_ret  = active && !take_ext && !take_jump && (exec_return || exec_int_return);
        take_low  = active && !take_ext && !take_jump && !take_ret && pc_low_wr_en;
        redirect  = take_jump || take_ret || take_low;
        take_skip = active && !take_ext && !redirect && exec_skip;
        // full stack withholds the acknowledge; request stays pending outside
        take_irq  = active && !take_ext && !redirect && !take_skip && irq_req && !stk_full;
    end

    // call and interrupt acknowledge push, returns pop
    always_comb begin
        stk_push = cycle_end && ((take_jump && exec_call) || take_irq);
        stk_pop  = cycle_end && take_ret;
    end

    // pipeline next state
    always_comb begin
        nxt_state   = state_ff;
        nxt_pc      = pc_ff;
        nxt_fetch   = fetch_ff;
        nxt_exec_ir = exec_ir_ff;
        // word addressed during the first phase is caught at its end
        if (phase_first) begin
            nxt_fetch = prog_data;
        end
        if (cycle_end) begin
            // prefetched word moves to execute, pc steps to next word
            nxt_pc      = pc_inc(pc_ff);
            nxt_exec_ir = fetch_ff;
            nxt_state   = SEQ_RUN;
            if (take_ext) begin
                // second half of extended word: hold pc and execute word
                nxt_pc      = pc_ff;
                nxt_exec_ir = exec_ir_ff;
                nxt_state   = SEQ_EXT;
            end else if (take_jump) begin
                nxt_pc    = exec_target;
                nxt_state = SEQ_DUMMY;
            end else if (take_ret) begin
                nxt_pc    = stk_top;
                nxt_state = SEQ_DUMMY;
            end else if (take_low) begin
                // only the low byte moves, page stays
                nxt_pc    = {pc_ff[PC_W-1:PC_LO_W], pc_low_wr_data};
                nxt_state = SEQ_DUMMY;
            end else if (take_skip) begin
                // default step takes pc past the skipped word; its prefetch is dropped
                nxt_state = SEQ_DUMMY;
            end else if (take_irq) begin
                nxt_pc    = irq_vector;
                nxt_state = SEQ_DUMMY;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // first cycle is a dummy that fetches the reset vector
            state_ff   <= SEQ_DUMMY;
            pc_ff      <= RESET_VECTOR;
            fetch_ff   <= IDLE_WORD;
            exec_ir_ff <= IDLE_WORD;
        end else begin
            state_ff   <= nxt_state;
            pc_ff      <= nxt_pc;
            fetch_ff   <= nxt_fetch;
            exec_ir_ff <= nxt_exec_ir;
        end
    end

    // outputs
    always_comb begin
        prog_addr           = pc_ff;
        prog_rd_en          = phase_first;
        instr_word          = exec_ir_ff;
        instr_valid         = (state_ff != SEQ_DUMMY);
        program_counter_low = pc_ff[PC_LO_W-1:0];
        irq_ack             = cycle_end && take_irq;
        stack_full          = stk_full;
    end

    // dummy run length, only feeds the checks
    always_comb begin
        nxt_dummy_len = '0;
        if (!instr_valid) begin
            nxt_dummy_len = dummy_len_ff + DUMMY_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dummy_len_ff <= '0;
        end else begin
            dummy_len_ff <= nxt_dummy_len;
        end
    end

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_dummy_cycle;
        !instr_valid [*4];
    endsequence

    sequence s_back_to_run;
        s_dummy_cycle ##1 instr_valid;
    endsequence

    sequence s_full_cycle;
        instruction_phases[PH_T1] ##3 cycle_end;
    endsequence

    a_phase_onehot: assert property ($onehot(instruction_phases))
        else $error("phases not one-hot");

    a_phase_wrap: assert property (cycle_end |=> s_full_cycle)
        else $error("instruction cycle is not four phases");

    a_pc_at_t1: assert property (!$stable(prog_addr) |-> instruction_phases[PH_T1])
        else $error("pc moved outside first phase");

    a_pc_step_one: assert property (cycle_end && active && !take_ext && !redirect && !take_irq
            |=> prog_addr == pc_inc($past(prog_addr)))
        else $error("pc did not step by one");

    a_ext_hold: assert property (cycle_end && take_ext
            |=> ($stable(prog_addr) && instr_valid) [*4] ##1 !$stable(prog_addr))
        else $error("extended word not held two cycles");

    a_branch_dummy: assert property (cycle_end && take_jump
            |=> (prog_addr == $past(exec_target)) ##0 s_back_to_run)
        else $error("branch target or dummy cycle wrong");

    a_skip_discard: assert property (cycle_end && take_skip |=> s_back_to_run)
        else $error("skip did not discard prefetch");

    a_low_page: assert property (cycle_end && take_low
            |=> prog_addr == {$past(pc_ff[PC_W-1:PC_LO_W]), $past(pc_low_wr_data)} ##0 s_dummy_cycle)
        else $error("low byte write left the page");

    a_ret_restore: assert property (cycle_end && take_ret |=> prog_addr == $past(stk_top))
        else $error("return did not restore pc");

    a_irq_withheld: assert property (irq_req && stack_full |-> !irq_ack)
        else $error("interrupt acknowledged with full stack");

    a_irq_vector: assert property (irq_ack |=> prog_addr == $past(irq_vector) ##0 s_dummy_cycle)
        else $error("interrupt vector not loaded");

    sequence s_pc_next;
        prog_addr == pc_inc($past(prog_addr));
    endsequence

    a_rd_en_first: assert property (prog_rd_en == instruction_phases[PH_T1])
        else $error("fetch strobe outside first phase");

    a_pcl_mirror: assert property (program_counter_low == prog_addr[PC_LO_W-1:0])
        else $error("low byte does not mirror the pc");

    a_word_at_t1: assert property (!$stable(instr_word) |-> instruction_phases[PH_T1])
        else $error("executed word moved outside first phase");

    a_ext_word: assert property (cycle_end && take_ext |=> $stable(instr_word) [*4])
        else $error("extended word not held");

    a_valid_at_t1: assert property (!$stable(instr_valid) |-> instruction_phases[PH_T1])
        else $error("valid flag moved outside first phase");

    // dummy cycle checks
    a_dummy_len: assert property (dummy_len_ff <= DUMMY_W'(NUM_PHASES))
        else $error("dummy stretch longer than one cycle");

    a_dummy_ignore: assert property (cycle_end && !active |=> s_pc_next ##0 instr_valid)
        else $error("dummy cycle did not step to a real cycle");

    a_skip_step: assert property (cycle_end && take_skip |=> s_pc_next)
        else $error("skip moved the pc off its step");

    // stack side
    a_call_push: assert property (cycle_end && take_jump && exec_call
            |=> stk_top == $past(pc_ff))
        else $error("call did not save the return address");

    a_irq_push: assert property (irq_ack |=> stk_top == $past(pc_ff))
        else $error("interrupt did not save the return address");

    a_ret_pop: assert property (cycle_end && take_ret && !stk_empty |=> !stk_full)
        else $error("return did not pop the stack");

    a_full_call: assert property (cycle_end && take_jump && exec_call && stk_full |=> stk_full)
        else $error("call on full stack lost the full level");

    a_empty_ret: assert property (cycle_end && take_ret && stk_empty |=> stk_empty)
        else $error("return on empty stack moved the level");

    a_ack_last: assert property (irq_ack |-> instruction_phases[PH_T4] && instr_valid)
        else $error("interrupt acknowledge outside a real last phase");

endmodule

/* pss_sequencer_tb.sv */
// self-checking bench for the program sequencer
`timescale 1ns/1ns
module pss_sequencer_tb;
    import pss_pkg::*;
    localparam logic [6:0] K_EXT = 7'h40, K_JMP = 7'h20, K_CALL = 7'h10, K_RET = 7'h08;
    localparam logic [6:0] K_IRET = 7'h04, K_SKIP = 7'h02, K_PCW = 7'h01;
    logic                  core_clk, rst_n, prog_rd_en, instr_valid, irq_ack, stack_full, irq_req;
    logic                  exec_ext, exec_jump, exec_call, exec_return, exec_int_return, exec_skip;
    logic                  pc_low_wr_en;
    logic [NUM_PHASES-1:0] instruction_phases;
    logic [PC_W-1:0]       prog_addr, exec_target, irq_vector, ra;
    logic [INSTR_W-1:0]    prog_data, instr_word;
    logic [PC_LO_W-1:0]    pc_low_wr_data, program_counter_low;
    logic [PC_W-1:0]       ra_q[$];
    int                    n_fail = 0, checks_done = 0, n_ack = 0, k;

    pss_sequencer #(.STACK_LEVELS(8)) i_dut (.core_clk, .rst_n, .instruction_phases, .prog_addr,
        .prog_rd_en, .prog_data, .instr_word, .instr_valid, .exec_ext, .exec_jump, .exec_call,
        .exec_return, .exec_int_return, .exec_skip, .exec_target, .pc_low_wr_en, .pc_low_wr_data,
        .program_counter_low, .irq_req, .irq_vector, .irq_ack, .stack_full);
    pss_prog_mem i_mem (.prog_addr(prog_addr), .prog_rd_en(prog_rd_en), .prog_data(prog_data));

    function automatic logic [15:0] wd(input logic [PC_W-1:0] a);
        wd = {3'h5, a};
    endfunction

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chk_pc(input logic [PC_W-1:0] exp, input logic vld);
        check("prog_addr", 16'(prog_addr), 16'(exp));
        check("instr_valid", 16'(instr_valid), 16'(vld));
    endtask

    // one request set, presented for the last-phase clock only
    task automatic issue(input logic [6:0] kind, input logic [PC_W-1:0] t);
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while (!(instruction_phases[2] === 1'b1 && instr_valid === 1'b1) && k < 64);
        if (k >= 64) begin
            n_fail++;
        end
        @(posedge core_clk);
        {exec_ext, exec_jump, exec_call, exec_return, exec_int_return, exec_skip, pc_low_wr_en} <= kind;
        exec_target <= t;
        pc_low_wr_data <= t[7:0];
        #1;
        ra = prog_addr;
        @(posedge core_clk);
        {exec_ext, exec_jump, exec_call, exec_return, exec_int_return, exec_skip, pc_low_wr_en} <= 7'h00;
        #1;
    endtask

    // end of the dummy cycle: target word executes, pc one past it
    task automatic follow(input logic [PC_W-1:0] t);
        repeat (4) @(posedge core_clk);
        #1;
        chk_pc(t + 13'h0001, 1'b1);
        check("instr_word", instr_word, wd(t));
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(negedge core_clk) begin
        if (irq_ack === 1'b1) begin
            n_ack <= n_ack + 1;
        end
    end

    initial begin
        #200000;
        n_fail++;
        $display("Error watchdog expired");
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        irq_req = 1'b0;
        irq_vector = 13'h0000;
        exec_target = 13'h0000;
        pc_low_wr_data = 8'h00;
        {exec_ext, exec_jump, exec_call, exec_return, exec_int_return, exec_skip, pc_low_wr_en} = 7'h00;
        repeat (3) @(posedge core_clk);
        #1;
        check("phases", 16'(instruction_phases), 16'h0001);
        chk_pc(13'h0000, 1'b0);
        check("stack_full", 16'(stack_full), 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while (instr_valid !== 1'b1 && k < 16);
        check("valid_delay", 16'(k), 16'h0004);
        check("instr_word", instr_word, wd(13'h0000));
        for (int i = 0; i < 4; i++) begin
            check("phases", 16'(instruction_phases), 16'(4'h1 << i));
            check("prog_rd_en", 16'(prog_rd_en), 16'(i == 0));
            chk_pc(13'h0001, 1'b1);
            @(posedge core_clk);
            #1;
        end
        chk_pc(13'h0002, 1'b1);
        issue(K_JMP, 13'h1AF0);
        chk_pc(13'h1AF0, 1'b0);
        follow(13'h1AF0);
        issue(K_EXT, 13'h0000);
        chk_pc(ra, 1'b1);
        check("instr_word", instr_word, wd(ra - 13'h0001));
        repeat (4) @(posedge core_clk);
        #1;
        chk_pc(ra + 13'h0001, 1'b1);
        issue(K_SKIP, 13'h0000);
        chk_pc(ra + 13'h0001, 1'b0);
        follow(ra + 13'h0001);
        issue(K_PCW, 13'h0055);
        chk_pc({ra[12:8], 8'h55}, 1'b0);
        check("pcl", 16'(program_counter_low), 16'h0055);
        follow({ra[12:8], 8'h55});
        for (int i = 0; i < 9; i++) begin
            issue(K_CALL, 13'h0100 + 13'(i * 16));
            ra_q.push_back(ra);
            if (ra_q.size() > 8) begin
                void'(ra_q.pop_front());
            end
            chk_pc(13'h0100 + 13'(i * 16), 1'b0);
            check("stack_full", 16'(stack_full), 16'(i >= 7));
        end
        @(posedge core_clk);
        irq_req <= 1'b1;
        irq_vector <= 13'h0004;
        repeat (16) @(posedge core_clk);
        check("ack_count", 16'(n_ack), 16'h0000);
        issue(K_RET, 13'h0000);
        chk_pc(ra_q.pop_back(), 1'b0);
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while (irq_ack !== 1'b1 && k < 32);
        check("irq_ack", 16'(irq_ack), 16'h0001);
        ra_q.push_back(prog_addr);
        @(posedge core_clk);
        irq_req <= 1'b0;
        #1;
        chk_pc(13'h0004, 1'b0);
        check("stack_full", 16'(stack_full), 16'h0001);
        issue(K_IRET, 13'h0000);
        chk_pc(ra_q.pop_back(), 1'b0);
        while (ra_q.size() > 0) begin
            issue(K_RET, 13'h0000);
            chk_pc(ra_q.pop_back(), 1'b0);
        end
        issue(K_RET, 13'h0000);
        check("stack_full", 16'(stack_full), 16'h0000);
        check("instr_valid", 16'(instr_valid), 16'h0000);
        check("ack_count", 16'(n_ack), 16'h0001);
        stop_test();
    end
endmodule
